// [common/uctc_pkg.sv]
package uctc_pkg;
   localparam logic [7:0]  OFS_CTRL1 = 8'h00;
   localparam logic [7:0]  OFS_CTRL2 = 8'h04;
   localparam logic [7:0]  OFS_PRS   = 8'h08;
   localparam logic [7:0]  OFS_CMPA  = 8'h0C;
   localparam logic [7:0]  OFS_CMPB  = 8'h10;
   localparam logic [7:0]  OFS_CNT   = 8'h14;
   localparam logic [7:0]  OFS_FLAGS = 8'h18;
   localparam logic [7:0]  OFS_IER   = 8'h1C;
   localparam logic [7:0]  OFS_TRG   = 8'h20;
   localparam logic [7:0]  OFS_SYNC  = 8'h24;
   localparam logic [7:0]  OFS_SNAP  = 8'h28;
   localparam logic [31:0] CTRL1_MASK = 32'h0000F9FF;
   localparam logic [31:0] SYNC_MASK  = 32'h0FF3FFFF;
   localparam logic [31:0] RST_ZERO   = 32'h00000000;
   localparam int MODE_LSB  = 0;
   localparam int EDGE_LSB  = 2;
   localparam int SRC_LSB   = 4;
   localparam int START_BIT = 7;
   localparam int ADC_BIT   = 8;
   localparam int DIR_BIT   = 11;
   localparam int INV_BIT   = 12;
   localparam int IMM_BIT   = 13;
   localparam int TRG_LSB   = 14;
   localparam int RUN_BIT   = 0;
   localparam int CLR_BIT   = 1;
   localparam int FLAG_A    = 2;
   localparam int FLAG_B    = 1;
   localparam int FLAG_WRAP = 0;
   typedef enum logic [1:0] {
      UCTC_PERIODIC = 2'h0,
      UCTC_PWM      = 2'h1,
      UCTC_ONESHOT  = 2'h2,
      UCTC_CAPTURE  = 2'h3
   } uctc_mode_t;
   typedef enum logic [1:0] {
      UCTC_CE_RISE = 2'h0,
      UCTC_CE_FALL = 2'h1,
      UCTC_CE_BOTH = 2'h2,
      UCTC_CE_NONE = 2'h3
   } uctc_edge_t;
endpackage

// [common/uctc_tick_if.sv]
`timescale 1ns/10ps
interface uctc_tick_if #(parameter int PRS_W = 10);
   logic [2:0]       src_sel;
   logic [PRS_W-1:0] div;
   logic             restart;
   logic             pin_lvl;
   logic             ext_lvl;
   logic             tick;
   modport core (output src_sel, div, restart, pin_lvl, ext_lvl, input tick);
   modport pre  (input src_sel, div, restart, pin_lvl, ext_lvl, output tick);
endinterface

// [hdl/uctc_prescaler.sv]
`timescale 1ns/10ps
module uctc_prescaler #(
   parameter int PRS_W = 10
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   uctc_tick_if.pre  tk
);
   logic [5:0]       base_r;
   logic [PRS_W-1:0] pre_r;
   logic             pin_d_r;
   logic             ext_d_r;
   logic             tick_r;
   logic             src_evt;

   // base divider, restarted by each clear write, gives the four fixed ratios
   always_ff @(posedge ref_clk) begin
      if (rst || tk.restart) begin
         base_r <= 6'h00;
      end else begin
         base_r <= base_r + 6'h01;
      end
   end

   // levels arrive already synchronised; only the edge is taken here
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_d_r <= 1'b0;
         ext_d_r <= 1'b0;
      end else begin
         pin_d_r <= tk.pin_lvl;
         ext_d_r <= tk.ext_lvl;
      end
   end

   always_comb begin
      case (tk.src_sel)
         3'h0:     src_evt = base_r[0];
         3'h1:     src_evt = &base_r[1:0];
         3'h2:     src_evt = &base_r[3:0];
         3'h3:     src_evt = &base_r[5:0];
         3'h4,
         3'h5:     src_evt = tk.ext_lvl & ~ext_d_r;
         default:  src_evt = tk.pin_lvl & ~pin_d_r;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst || tk.restart) begin
         pre_r  <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= 1'b0;
         if (src_evt) begin
            if (pre_r == tk.div) begin
               pre_r  <= '0;
               tick_r <= 1'b1;
            end else begin
               pre_r <= pre_r + 1'b1;
            end
         end
      end
   end

   assign tk.tick = tick_r;
endmodule

// [hdl/uctc_timer.sv]
// Added by the designer: the Wishbone register port.
`timescale 1ns/10ps
module uctc_timer #(
   parameter int CNT_W = 16,
   parameter int PRS_W = 10
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        wb_cyc,
   input  wire logic        wb_stb,
   input  wire logic        wb_we,
   input  wire logic [7:0]  wb_adr,
   input  wire logic [3:0]  wb_sel,
   input  wire logic [31:0] wb_wdata,
   output logic      [31:0] wb_rdata,
   output logic             wb_ack,
   input  wire logic        timer_io_pin_rx,
   output logic             timer_io_pin_tx,
   output logic             timer_io_pin_oe,
   input  wire logic        external_clock_source,
   output logic             adc_trigger,
   output logic             irq
);
   if (CNT_W != 16 || PRS_W < 1 || PRS_W > 16) begin : g_chk
      $error("uctc_timer: unsupported width");
   end

   logic [31:0]       ctrl1_r;
   logic              run_r;
   logic [PRS_W-1:0]  prs_r;
   logic [15:0]       cmp_a_r;
   logic [15:0]       cmp_b_r;
   logic [15:0]       cnt_r;
   logic [2:0]        flags_r;
   logic [2:0]        ier_r;
   logic [15:0]       trg_r;
   logic [31:0]       sync_r;
   logic [15:0]       snap_r;
   logic [15:0]       buf_a_r;
   logic [15:0]       buf_b_r;
   logic              done_r;
   logic              wave_r;
   logic              ack_r;
   logic [31:0]       dat_r;
   logic              pin_tx_r;
   logic              pin_oe_r;
   logic              adc_r;
   logic              irq_r;
   logic              pin_s1_r;
   logic              pin_s2_r;
   logic              pin_s3_r;
   logic              ext_s1_r;
   logic              ext_s2_r;
   logic [31:0]       rd_nxt;
   logic              req;
   logic              wr;
   logic              clr_wr;
   logic              cnt_wr;
   logic [2:0]        flag_clr;
   logic [2:0]        flag_set;
   logic              go;
   logic              step;
   logic [15:0]       cnt_inc;
   logic              a_hit;
   logic              b_hit;
   logic              tp_hit;
   logic              wrap;
   logic              rise;
   logic              fall;
   logic              cap_clr;
   logic              cap_a;
   logic              cap_b;
   logic              is_cap;
   logic [1:0]        tmode;
   uctc_pkg::uctc_mode_t mode;
   uctc_pkg::uctc_edge_t cedge;

   uctc_tick_if #(.PRS_W(PRS_W)) tk ();

   uctc_prescaler #(.PRS_W(PRS_W)) u_pre (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tk      (tk)
   );

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic hit(input logic [7:0] ofs);
      return wr && (wb_adr == ofs);
   endfunction

   assign req      = wb_cyc & wb_stb & ~ack_r;
   assign wr       = req & wb_we;
   assign clr_wr   = hit(uctc_pkg::OFS_CTRL2) & wb_sel[0] & wb_wdata[uctc_pkg::CLR_BIT];
   assign cnt_wr   = hit(uctc_pkg::OFS_CNT);
   assign flag_clr = (hit(uctc_pkg::OFS_FLAGS) && wb_sel[0]) ? wb_wdata[2:0] : 3'h0;

   assign mode    = uctc_pkg::uctc_mode_t'(ctrl1_r[uctc_pkg::MODE_LSB +: 2]);
   assign cedge   = uctc_pkg::uctc_edge_t'(ctrl1_r[uctc_pkg::EDGE_LSB +: 2]);
   assign tmode   = ctrl1_r[uctc_pkg::TRG_LSB +: 2];
   assign is_cap  = (mode == uctc_pkg::UCTC_CAPTURE);
   assign go      = run_r & (buf_b_r != 16'h0000) & ~done_r;
   assign step    = go & tk.tick;
   assign cnt_inc = cnt_r + 16'h0001;
   // compares look one count ahead so a period of B ticks runs 0..B-1
   assign b_hit   = step & ~is_cap & (cnt_inc == buf_b_r);
   assign a_hit   = step & ~is_cap & (cnt_inc == buf_a_r);
   assign tp_hit  = step & (cnt_inc == trg_r);
   assign wrap    = step & ~b_hit & (cnt_r == 16'hFFFF);
   assign rise    = pin_s2_r & ~pin_s3_r;
   assign fall    = ~pin_s2_r & pin_s3_r;
   assign cap_a   = run_r & is_cap & ((cedge == uctc_pkg::UCTC_CE_FALL) ? rise : fall);
   assign cap_b   = run_r & is_cap & ((cedge == uctc_pkg::UCTC_CE_FALL) ? fall : rise);
   assign flag_set = {a_hit | cap_a, b_hit | cap_b, wrap};

   always_comb begin
      case (cedge)
         uctc_pkg::UCTC_CE_RISE: cap_clr = go & is_cap & rise;
         uctc_pkg::UCTC_CE_FALL: cap_clr = go & is_cap & fall;
         uctc_pkg::UCTC_CE_BOTH: cap_clr = go & is_cap & (rise | fall);
         default:                cap_clr = 1'b0;
      endcase
   end

   assign tk.src_sel = ctrl1_r[uctc_pkg::SRC_LSB +: 3];
   assign tk.div     = prs_r;
   assign tk.restart = clr_wr;
   assign tk.pin_lvl = pin_s2_r;
   assign tk.ext_lvl = ext_s2_r;

   // pin and external clock come from outside the clock domain
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
         pin_s3_r <= 1'b0;
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
      end else begin
         pin_s1_r <= timer_io_pin_rx;
         pin_s2_r <= pin_s1_r;
         pin_s3_r <= pin_s2_r;
         ext_s1_r <= external_clock_source;
         ext_s2_r <= ext_s1_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl1_r <= uctc_pkg::RST_ZERO;
         run_r   <= 1'b0;
         prs_r   <= '0;
         ier_r   <= 3'h0;
         trg_r   <= 16'h0000;
         sync_r  <= uctc_pkg::RST_ZERO;
      end else begin
         if (hit(uctc_pkg::OFS_CTRL1)) begin
            ctrl1_r <= wmerge(ctrl1_r, wb_wdata, wb_sel) & uctc_pkg::CTRL1_MASK;
         end
         if (hit(uctc_pkg::OFS_CTRL2) && wb_sel[0]) begin
            run_r <= wb_wdata[uctc_pkg::RUN_BIT];
         end
         if (hit(uctc_pkg::OFS_PRS)) begin
            prs_r <= PRS_W'(wmerge(32'(prs_r), wb_wdata, wb_sel));
         end
         if (hit(uctc_pkg::OFS_IER) && wb_sel[0]) begin
            ier_r <= wb_wdata[2:0];
         end
         if (hit(uctc_pkg::OFS_TRG)) begin
            trg_r <= 16'(wmerge(32'(trg_r), wb_wdata, wb_sel));
         end
         if (hit(uctc_pkg::OFS_SYNC)) begin
            sync_r <= wmerge(sync_r, wb_wdata, wb_sel) & uctc_pkg::SYNC_MASK;
         end
      end
   end

   // a capture edge wins over a bus write in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cmp_a_r <= 16'h0000;
         cmp_b_r <= 16'h0000;
      end else begin
         if (cap_a) begin
            cmp_a_r <= cnt_r;
         end else if (hit(uctc_pkg::OFS_CMPA)) begin
            cmp_a_r <= 16'(wmerge(32'(cmp_a_r), wb_wdata, wb_sel));
         end
         if (cap_b) begin
            cmp_b_r <= cnt_r;
         end else if (hit(uctc_pkg::OFS_CMPB)) begin
            cmp_b_r <= 16'(wmerge(32'(cmp_b_r), wb_wdata, wb_sel));
         end
      end
   end

   // compare buffers hide software writes until the period ends
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         buf_a_r <= 16'h0000;
         buf_b_r <= 16'h0000;
      end else if (ctrl1_r[uctc_pkg::IMM_BIT] || clr_wr || b_hit) begin
         buf_a_r <= cmp_a_r;
         buf_b_r <= cmp_b_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r <= 16'h0000;
      end else if (clr_wr) begin
         cnt_r <= 16'h0000;
      end else if (cnt_wr) begin
         cnt_r <= 16'(wmerge(32'(cnt_r), wb_wdata, wb_sel));
      end else if (b_hit || cap_clr) begin
         cnt_r <= 16'h0000;
      end else if (step) begin
         cnt_r <= cnt_inc;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         done_r <= 1'b0;
      end else if (clr_wr) begin
         done_r <= 1'b0;
      end else if (b_hit && mode == uctc_pkg::UCTC_ONESHOT) begin
         done_r <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         snap_r <= 16'h0000;
      end else if (a_hit || clr_wr) begin
         snap_r <= cnt_r;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wave_r <= 1'b0;
      end else if (clr_wr) begin
         wave_r <= ctrl1_r[uctc_pkg::START_BIT];
      end else if (b_hit && mode != uctc_pkg::UCTC_PERIODIC) begin
         wave_r <= ctrl1_r[uctc_pkg::START_BIT];
      end else if (a_hit) begin
         if (mode == uctc_pkg::UCTC_PERIODIC) begin
            wave_r <= (buf_a_r != 16'h0000) ? ~wave_r : wave_r;
         end else begin
            wave_r <= ~ctrl1_r[uctc_pkg::START_BIT];
         end
      end
   end

   // set beats the write-one clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         flags_r <= 3'h0;
      end else begin
         flags_r <= (flags_r & ~flag_clr) | flag_set;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_tx_r <= 1'b0;
         pin_oe_r <= 1'b0;
         adc_r    <= 1'b0;
         irq_r    <= 1'b0;
      end else begin
         pin_tx_r <= wave_r ^ ctrl1_r[uctc_pkg::INV_BIT];
         pin_oe_r <= ctrl1_r[uctc_pkg::DIR_BIT];
         adc_r    <= ctrl1_r[uctc_pkg::ADC_BIT] & ((~tmode[1] & a_hit) | (tmode[1] & tp_hit) |
                     ((tmode == 2'h3) & a_hit));
         irq_r    <= |(flags_r & ier_r);
      end
   end

   always_comb begin
      case (wb_adr)
         uctc_pkg::OFS_CTRL1: rd_nxt = ctrl1_r;
         uctc_pkg::OFS_CTRL2: rd_nxt = {31'h00000000, run_r};
         uctc_pkg::OFS_PRS:   rd_nxt = 32'(prs_r);
         uctc_pkg::OFS_CMPA:  rd_nxt = {16'h0000, cmp_a_r};
         uctc_pkg::OFS_CMPB:  rd_nxt = {16'h0000, cmp_b_r};
         uctc_pkg::OFS_CNT:   rd_nxt = {16'h0000, cnt_r};
         uctc_pkg::OFS_FLAGS: rd_nxt = {29'h00000000, flags_r};
         uctc_pkg::OFS_IER:   rd_nxt = {29'h00000000, ier_r};
         uctc_pkg::OFS_TRG:   rd_nxt = {16'h0000, trg_r};
         uctc_pkg::OFS_SYNC:  rd_nxt = sync_r;
         uctc_pkg::OFS_SNAP:  rd_nxt = {16'h0000, snap_r};
         default:             rd_nxt = uctc_pkg::RST_ZERO;
      endcase
   end

   // one wait state: ack always comes the edge after the request is seen
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
         dat_r <= uctc_pkg::RST_ZERO;
      end else begin
         ack_r <= req;
         dat_r <= (req && !wb_we) ? rd_nxt : uctc_pkg::RST_ZERO;
      end
   end

   assign wb_ack          = ack_r;
   assign wb_rdata        = dat_r;
   assign timer_io_pin_tx = pin_tx_r;
   assign timer_io_pin_oe = pin_oe_r;
   assign adc_trigger     = adc_r;
   assign irq             = irq_r;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_ack_single: assert property (wb_ack |=> !wb_ack)
      else $error("ack longer than one cycle");
   a_clear_zero: assert property (clr_wr |=> cnt_r == 16'h0000)
      else $error("clear did not zero counter");
   a_stop_hold: assert property (!run_r && !cnt_wr && !clr_wr |=> $stable(cnt_r))
      else $error("counter moved while stopped");
   a_zero_period: assert property (buf_b_r == 16'h0000 && !cnt_wr && !clr_wr |=> $stable(cnt_r))
      else $error("counter moved with zero period");
   a_adc_gate: assert property (adc_trigger |-> $past(ctrl1_r[uctc_pkg::ADC_BIT]))
      else $error("adc trigger while disabled");
   a_pin_dir: assert property (##1 timer_io_pin_oe == $past(ctrl1_r[uctc_pkg::DIR_BIT]))
      else $error("pin enable does not follow direction");
   a_irq_mask: assert property (##1 irq == $past(|(flags_r & ier_r)))
      else $error("interrupt not gated by enable");
   a_flag_set: assert property (a_hit |=> flags_r[uctc_pkg::FLAG_A])
      else $error("match flag lost");
   a_wrap_flag: assert property (wrap && !cnt_wr |=> flags_r[uctc_pkg::FLAG_WRAP] && cnt_r == 16'h0000)
      else $error("wrap not flagged");
   a_clear_level: assert property (clr_wr |=> wave_r == $past(ctrl1_r[uctc_pkg::START_BIT]))
      else $error("clear did not restore start level");
   a_period_end: assert property (b_hit && !clr_wr && !cnt_wr |=> cnt_r == 16'h0000 ##2 !timer_io_pin_tx ||
      mode != uctc_pkg::UCTC_PWM || $past(ctrl1_r[uctc_pkg::START_BIT] ^ ctrl1_r[uctc_pkg::INV_BIT], 2))
      else $error("pwm period end wrong");

   c_period: cover property (b_hit && mode == uctc_pkg::UCTC_PERIODIC);
   c_pwm_duty: cover property (a_hit && mode == uctc_pkg::UCTC_PWM);
   c_capture: cover property (cap_clr ##1 cap_a);
   c_adc: cover property (adc_trigger);
endmodule

// [test/uctc_pin_model.sv]
`timescale 1ns/10ps
module uctc_pin_model (
   input  wire logic        ref_clk,
   input  wire logic        pin_oe,
   input  wire logic        pin_tx,
   input  wire logic        adc_trigger,
   input  wire logic        gen_en,
   output logic             pin_rx,
   output logic [15:0]      adc_count
);
   logic [4:0] div_r;
   initial begin
      pin_rx = 1'b1;
      adc_count = 16'h0000;
      div_r = 5'h00;
   end
   // released pin floats to its pull-up only while gen_en is low; with gen_en set it holds its level and toggles every 32 cycles
   always @(posedge ref_clk) begin
      div_r <= div_r + 5'h01;
      if (adc_trigger === 1'b1) begin
         adc_count <= adc_count + 16'h0001;
      end
      if (pin_oe === 1'b1) begin
         pin_rx <= pin_tx;
      end else if (gen_en && div_r == 5'h1F) begin
         pin_rx <= ~pin_rx;
      end else if (!gen_en) begin
         pin_rx <= 1'b1;
      end
   end
endmodule

// [test/uctc_timer_tb.sv]
`timescale 1ns/10ps
module uctc_timer_tb;
   logic        ref_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, gen_en, ext_clk;
   logic        pin_rx, pin_tx, pin_oe, adc_trigger, irq;
   logic [7:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_wdata, wb_rdata, rd, d;
   logic [15:0] adc_count, a0;
   logic [31:0] exp_q[$];
   logic [7:0]  ofs[8] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h24};
   logic [31:0] msk[8] = '{32'h0000F9FF, 32'h000003FF, 32'h0000FFFF, 32'h0000FFFF,
                           32'h0000FFFF, 32'h00000007, 32'h0000FFFF, 32'h0FF3FFFF};
   int          errors = 0;
   int          cmp_count = 0;
   int          seed = 32'h13f7f832;
   int          n0;

   uctc_timer uctc_timer_i (.ref_clk(ref_clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
      .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_wdata(wb_wdata), .wb_rdata(wb_rdata),
      .wb_ack(wb_ack), .timer_io_pin_rx(pin_rx), .timer_io_pin_tx(pin_tx), .timer_io_pin_oe(pin_oe),
      .external_clock_source(ext_clk), .adc_trigger(adc_trigger), .irq(irq));
   uctc_pin_model uctc_pin_model_i (.ref_clk(ref_clk), .pin_oe(pin_oe), .pin_tx(pin_tx),
      .adc_trigger(adc_trigger), .gen_en(gen_en), .pin_rx(pin_rx), .adc_count(adc_count));

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   task summarize;
      $display("checks %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // classic cycle: request held until ack is sampled, then released for a cycle
   task wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge ref_clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_wdata <= dat;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack !== 1'b1 && n < 100);
      rd = wb_rdata;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      if (n >= 100) chk("ack", 0, 1);
   endtask

   task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h00000000);
      chk(nm, rd, e);
   endtask

   task go(input int k);
      wb(1'b1, 8'h04, 32'h00000002);
      wb(1'b1, 8'h04, 32'h00000001);
      repeat (k) @(posedge ref_clk);
      wb(1'b1, 8'h04, 32'h00000000);
   endtask

   initial begin
      #(20000 * 50);
      errors++;
      $display("watchdog expired");
      summarize;
   end

   initial begin
      rst = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'hF;
      wb_wdata = 32'h00000000;
      gen_en = 1'b0;
      ext_clk = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 12; i++) rdc("reset value", 8'(i * 4), 32'h00000000);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         d = $random(seed);
         wb(1'b1, ofs[i], d);
         exp_q.push_back(d & msk[i]);
      end
      for (int i = 0; i < 8; i++) rdc("readback", ofs[i], exp_q.pop_front());
      wb(1'b1, 8'h2C, 32'hFFFFFFFF);
      rdc("unmapped", 8'h2C, 32'h00000000);
      $display("register test done");
      wb(1'b1, 8'h00, 32'h00000900);
      wb(1'b1, 8'h08, 32'h00000000);
      wb(1'b1, 8'h0C, 32'h00000001);
      wb(1'b1, 8'h10, 32'h00000003);
      wb(1'b1, 8'h1C, 32'h00000007);
      wb(1'b1, 8'h18, 32'h00000007);
      a0 = adc_count;
      go(40);
      rdc("periodic flags", 8'h18, 32'h00000006);
      chk("irq on", irq, 1);
      chk("adc fired", adc_count != a0, 1);
      wb(1'b0, 8'h14, 32'h00000000);
      d = rd;
      chk("count range", d < 3, 1);
      repeat (10) @(posedge ref_clk);
      rdc("stopped count", 8'h14, d);
      wb(1'b1, 8'h18, 32'h00000002);
      rdc("write one clear", 8'h18, 32'h00000004);
      wb(1'b1, 8'h1C, 32'h00000002);
      repeat (2) @(posedge ref_clk);
      chk("irq masked", irq, 0);
      wb(1'b1, 8'h04, 32'h00000002);
      rdc("snapshot", 8'h28, d);
      rdc("cleared", 8'h14, 32'h00000000);
      rdc("clear bit", 8'h04, 32'h00000000);
      wb(1'b1, 8'h00, 32'h00000800);
      a0 = adc_count;
      go(40);
      chk("adc off", adc_count, a0);
      // trigger-point mode alone: compare A hits must not trigger, and a point past B never matches
      wb(1'b1, 8'h00, 32'h00008900);
      wb(1'b1, 8'h20, 32'h00000005);
      a0 = adc_count;
      go(40);
      chk("point unreached", adc_count, a0);
      wb(1'b1, 8'h20, 32'h00000002);
      go(40);
      chk("point fired", adc_count != a0, 1);
      $display("periodic test done");
      wb(1'b1, 8'h10, 32'h00000000);
      go(20);
      rdc("zero period", 8'h14, 32'h00000000);
      wb(1'b1, 8'h00, 32'h00000881);
      wb(1'b1, 8'h0C, 32'h00000002);
      wb(1'b1, 8'h10, 32'h00000004);
      wb(1'b1, 8'h04, 32'h00000002);
      repeat (3) @(posedge ref_clk);
      chk("start level", pin_tx, 1);
      chk("pin driven", pin_oe, 1);
      wb(1'b1, 8'h04, 32'h00000001);
      n0 = 0;
      repeat (40) begin
         @(posedge ref_clk);
         n0 += (pin_tx === 1'b0);
      end
      // period of 8 cycles, half of it at the opposite level
      chk("pwm duty", n0 >= 16 && n0 <= 24, 1);
      wb(1'b1, 8'h04, 32'h00000000);
      wb(1'b1, 8'h00, 32'h00001881);
      wb(1'b1, 8'h04, 32'h00000002);
      repeat (3) @(posedge ref_clk);
      chk("inverted start", pin_tx, 0);
      $display("pwm test done");
      wb(1'b1, 8'h00, 32'h00000802);
      wb(1'b1, 8'h10, 32'h00000005);
      wb(1'b1, 8'h18, 32'h00000007);
      go(60);
      rdc("one shot stop", 8'h14, 32'h00000000);
      rdc("one shot flags", 8'h18, 32'h00000006);
      $display("one shot test done");
      wb(1'b1, 8'h00, 32'h00000003);
      wb(1'b1, 8'h10, 32'h0000FFFF);
      wb(1'b1, 8'h18, 32'h00000007);
      gen_en <= 1'b1;
      go(300);
      wb(1'b0, 8'h18, 32'h00000000);
      chk("capture flags", rd[2:1], 2'b11);
      wb(1'b0, 8'h14, 32'h00000000);
      chk("capture clear", rd < 32'h00000040, 1);
      $display("capture test done");
      // capture without clearing and a quiet pin: only the wrap can set a flag
      gen_en <= 1'b0;
      wb(1'b1, 8'h00, 32'h0000000F);
      wb(1'b1, 8'h10, 32'h0000FFFF);
      wb(1'b1, 8'h18, 32'h00000007);
      wb(1'b1, 8'h04, 32'h00000002);
      wb(1'b1, 8'h14, 32'h0000FFFE);
      wb(1'b1, 8'h04, 32'h00000001);
      repeat (20) @(posedge ref_clk);
      wb(1'b1, 8'h04, 32'h00000000);
      rdc("wrap flag", 8'h18, 32'h00000001);
      wb(1'b0, 8'h14, 32'h00000000);
      chk("after wrap", rd < 32'h00000020, 1);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      rdc("reset count", 8'h14, 32'h00000000);
      rdc("reset flags", 8'h18, 32'h00000000);
      rdc("reset ctrl", 8'h00, 32'h00000000);
      $display("wrap and reset test done");
      summarize;
   end
endmodule
